// *** design/urs_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module urs_pin_sync #(
   parameter int WIDTH = 5
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pins and filtered levels
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Each bit follows only when stages two and three agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               stage1[i] <= 1'b0;
               stage2[i] <= 1'b0;
               stage3[i] <= 1'b0;
               level[i] <= 1'b0;
            end else begin
               stage1[i] <= pin[i];
               stage2[i] <= stage1[i];
               stage3[i] <= stage2[i];
               if (stage2[i] == stage3[i]) begin
                  level[i] <= stage3[i];
               end
            end
         end
      end
   endgenerate
endmodule : urs_pin_sync

// *** design/urs_pkg.sv ***
// Shared constants for the ULPI status byte sender
package urs_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] URS_OFS_CTRL = 4'h0;
   localparam logic [3:0] URS_OFS_EVENT = 4'h4;
   localparam logic [3:0] URS_OFS_MASK = 4'h8;
   localparam logic [3:0] URS_OFS_BYTE = 4'hc;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int URS_CTRL_ENABLE = 0;
   localparam int URS_CTRL_FORCE = 1;
   localparam int URS_EV_SENT = 0;
   localparam int URS_EV_SUPPLY = 1;
   localparam int URS_EV_PAIR = 2;
   localparam int URS_EV_WIDTH = 3;
   localparam logic [2:0] URS_EVENT_RESET = 3'h0;
   localparam logic [2:0] URS_MASK_RESET = 3'h0;
   localparam logic URS_ENABLE_RESET = 1'b1;
   // ----------------------------------------------------------------
   // Status byte layout and supply codes
   // ----------------------------------------------------------------
   localparam int URS_BYTE_PAIR_LO = 0;
   localparam int URS_BYTE_SUPPLY_LO = 2;
   localparam int URS_BYTE_UPPER_LO = 4;
   localparam logic [1:0] URS_SUPPLY_BELOW_END = 2'h0;
   localparam logic [1:0] URS_SUPPLY_MID = 2'h1;
   localparam logic [1:0] URS_SUPPLY_SESSION = 2'h2;
   localparam logic [1:0] URS_SUPPLY_A_VALID = 2'h3;
   // ----------------------------------------------------------------
   // Bus answers and sender states
   // ----------------------------------------------------------------
   localparam logic [1:0] URS_RESP_OKAY = 2'h0;
   localparam logic [1:0] URS_RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {
      URS_ST_IDLE,
      URS_ST_TURN_IN,
      URS_ST_SEND,
      URS_ST_TURN_OUT
   } urs_state_type;
endpackage : urs_pkg

// *** design/urs_status_sender.sv ***
// ULPI status byte sender with AXI4-Lite control and interrupt
//
// Overview of operation
// - After raising dir, report pair, supply and upper status as one byte.
// - Send a fresh status byte unprompted whenever any field changes.
// - Bits 1:0 carry data pair condition, lower line in bit 0.
// - Bits 3:2 encode supply; 00 means below session end.
// - 01 between thresholds, 10 session valid, 11 A-device supply valid.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module urs_status_sender
   import urs_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Analog comparator and line pins
   input wire logic line_dp,
   input wire logic line_dm,
   input wire logic sess_end,
   input wire logic sess_vld,
   input wire logic a_device_supply_valid_flag,
   // Same-clock receive, disconnect and OTG bits
   input wire logic [3:0] upper_status,
   input wire logic link_busy,
   // ULPI side
   output logic ulpi_dir,
   output logic ulpi_nxt,
   output logic [7:0] ulpi_data_out,
   output logic ulpi_data_oe,
   // AXI4-Lite write
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt
   output logic irq
);
   // ----------------------------------------------------------------
   // Pin synchronisation and byte assembly
   // ----------------------------------------------------------------
   logic [4:0] pins_level;
   urs_pin_sync #(
      .WIDTH(5)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin({a_device_supply_valid_flag, sess_vld, sess_end, line_dm, line_dp}),
      .level(pins_level)
   );

   wire [1:0] data_pair_condition = pins_level[1:0];
   wire level_sess_end = pins_level[2];
   wire level_sess_vld = pins_level[3];
   wire level_a_valid = pins_level[4];

   // Supply code, highest threshold first
   wire [1:0] supply_code = level_a_valid ? URS_SUPPLY_A_VALID :
      level_sess_vld ? URS_SUPPLY_SESSION :
      level_sess_end ? URS_SUPPLY_BELOW_END :
      URS_SUPPLY_MID;

   // Live status byte
   wire [7:0] cur_byte = {upper_status, supply_code, data_pair_condition};

   // ----------------------------------------------------------------
   // Registers and bus decode
   // ----------------------------------------------------------------
   logic ctrl_enable;
   logic force_req;
   logic [URS_EV_WIDTH-1:0] event_flags;
   logic [URS_EV_WIDTH-1:0] event_mask;
   logic [7:0] last_sent;
   logic [7:0] prev_byte;
   logic aw_held;
   logic w_held;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   urs_state_type state;

   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire do_write = aw_held & w_held & ~s_axi_bvalid;
   wire wr_lane0 = do_write & w_strb[0];
   wire wr_ctrl = wr_lane0 & (aw_addr == URS_OFS_CTRL);
   wire wr_event = wr_lane0 & (aw_addr == URS_OFS_EVENT);
   wire wr_mask = wr_lane0 & (aw_addr == URS_OFS_MASK);
   wire wr_mapped = (aw_addr == URS_OFS_CTRL) | (aw_addr == URS_OFS_EVENT) |
      (aw_addr == URS_OFS_MASK) | (aw_addr == URS_OFS_BYTE);
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire rd_mapped = (s_axi_araddr == URS_OFS_CTRL) | (s_axi_araddr == URS_OFS_EVENT) |
      (s_axi_araddr == URS_OFS_MASK) | (s_axi_araddr == URS_OFS_BYTE);
   wire [31:0] rd_value =
      (s_axi_araddr == URS_OFS_CTRL) ? {30'h0, force_req, ctrl_enable} :
      (s_axi_araddr == URS_OFS_EVENT) ? {29'h0, event_flags} :
      (s_axi_araddr == URS_OFS_MASK) ? {29'h0, event_mask} :
      (s_axi_araddr == URS_OFS_BYTE) ? {16'h0, cur_byte, last_sent} : 32'h0;

   // ----------------------------------------------------------------
   // Sender state machine decode
   // ----------------------------------------------------------------
   wire change_pending = (cur_byte != last_sent);
   wire start_send = ctrl_enable & (change_pending | force_req) & ~link_busy;
   wire send_more = (cur_byte != ulpi_data_out);
   wire byte_loaded = (state == URS_ST_TURN_IN) |
      ((state == URS_ST_SEND) & send_more);

   // Event sources
   wire [URS_EV_WIDTH-1:0] ev_set;
   assign ev_set[URS_EV_SENT] = byte_loaded;
   assign ev_set[URS_EV_SUPPLY] = (cur_byte[3:2] != prev_byte[3:2]);
   assign ev_set[URS_EV_PAIR] = (cur_byte[1:0] != prev_byte[1:0]);
   wire [URS_EV_WIDTH-1:0] ev_clr = wr_event ? w_data[URS_EV_WIDTH-1:0] : '0;
   wire [URS_EV_WIDTH-1:0] next_event_flags = (event_flags & ~ev_clr) | ev_set;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= URS_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[3:2], 2'h0};
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid;
         s_axi_wready <= ~w_held & ~w_take & ~s_axi_bvalid;
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? URS_RESP_OKAY : URS_RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= URS_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_mapped ? URS_RESP_OKAY : URS_RESP_DECERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control, event and mask registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_enable <= URS_ENABLE_RESET;
         force_req <= 1'b0;
         event_flags <= URS_EVENT_RESET;
         event_mask <= URS_MASK_RESET;
         prev_byte <= 8'h0;
         irq <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_enable <= w_data[URS_CTRL_ENABLE];
         end
         // Force request survives until a send starts; set wins
         if (wr_ctrl & w_data[URS_CTRL_FORCE]) begin
            force_req <= 1'b1;
         end else if (state == URS_ST_IDLE && start_send) begin
            force_req <= 1'b0;
         end
         if (wr_mask) begin
            event_mask <= w_data[URS_EV_WIDTH-1:0];
         end
         event_flags <= next_event_flags;
         prev_byte <= cur_byte;
         irq <= |(next_event_flags & (wr_mask ? w_data[URS_EV_WIDTH-1:0] : event_mask));
      end
   end

   // ----------------------------------------------------------------
   // ULPI bus ownership and status byte sending
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= URS_ST_IDLE;
         ulpi_dir <= 1'b0;
         ulpi_nxt <= 1'b0;
         ulpi_data_out <= 8'h0;
         ulpi_data_oe <= 1'b0;
         last_sent <= 8'h0;
      end else begin
         ulpi_nxt <= 1'b0;
         case (state)
            URS_ST_IDLE: begin
               if (start_send) begin
                  ulpi_dir <= 1'b1;
                  state <= URS_ST_TURN_IN;
               end
            end
            URS_ST_TURN_IN: begin
               // Turnaround cycle done, drive the byte next
               ulpi_data_oe <= 1'b1;
               ulpi_data_out <= cur_byte;
               last_sent <= cur_byte;
               state <= URS_ST_SEND;
            end
            URS_ST_SEND: begin
               if (send_more) begin
                  ulpi_data_out <= cur_byte;
                  last_sent <= cur_byte;
               end else begin
                  ulpi_data_oe <= 1'b0;
                  ulpi_dir <= 1'b0;
                  state <= URS_ST_TURN_OUT;
               end
            end
            URS_ST_TURN_OUT: begin
               state <= URS_ST_IDLE;
            end
            default: begin
               state <= URS_ST_IDLE;
            end
         endcase
      end
   end
endmodule : urs_status_sender

// *** tb/urs_link_model.sv ***
// Link side model that takes every status byte
`timescale 1ns/1ps
module urs_link_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // ULPI from the device
   input wire logic ulpi_dir,
   input wire logic ulpi_nxt,
   input wire logic [7:0] ulpi_data_out,
   input wire logic ulpi_data_oe,
   // Captured bytes
   output logic got,
   output logic [7:0] got_byte
);
   // Accept a byte in any owned cycle with ulpi_data_oe high and nxt low
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         got <= 1'b0;
         got_byte <= 8'h00;
      end else begin
         got <= ulpi_dir && ulpi_data_oe && !ulpi_nxt;
         got_byte <= ulpi_data_out;
      end
   end
endmodule : urs_link_model

// *** tb/urs_status_sender_asserts.sv ***
// Port checker for the status byte sender
`timescale 1ns/1ps
module urs_status_sender_asserts (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pins and ULPI
   input wire logic line_dp,
   input wire logic line_dm,
   input wire logic sess_end,
   input wire logic sess_vld,
   input wire logic a_device_supply_valid_flag,
   input wire logic [3:0] upper_status,
   input wire logic ulpi_dir,
   input wire logic ulpi_nxt,
   input wire logic [7:0] ulpi_data_out,
   input wire logic ulpi_data_oe,
   // Bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Pin snapshot and expected supply code
   wire [8:0] pins = {upper_status, a_device_supply_valid_flag, sess_vld, sess_end,
      line_dm, line_dp};
   wire [1:0] code = a_device_supply_valid_flag ? 2'h3 : sess_vld ? 2'h2 : sess_end ? 2'h0 : 2'h1;
   logic [8:0] prev;
   logic [3:0] calm;
   // Cycles the pins have stayed put
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev <= 9'h000;
         calm <= 4'h0;
      end else begin
         prev <= pins;
         calm <= (pins != prev) ? 4'h0 : (calm == 4'hf) ? calm : calm + 4'h1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_nxt_low; ulpi_nxt == 1'b0; endproperty
   a_nxt_low: assert property (p_nxt_low) else $error("nxt raised");
   property p_oe_owned; ulpi_data_oe |-> ulpi_dir; endproperty
   a_oe_owned: assert property (p_oe_owned) else $error("byte without dir");
   property p_turn_in; $rose(ulpi_dir) |-> !ulpi_data_oe ##1 ulpi_data_oe; endproperty
   a_turn_in: assert property (p_turn_in) else $error("turnaround wrong");
   property p_drop; $fell(ulpi_data_oe) |-> !ulpi_dir ##1 !ulpi_dir; endproperty
   a_drop: assert property (p_drop) else $error("release wrong");
   property p_pair;
      ulpi_data_oe && calm > 4'h8 |-> ulpi_data_out[1:0] == {line_dm, line_dp};
   endproperty
   a_pair: assert property (p_pair) else $error("pair bits wrong");
   property p_supply; ulpi_data_oe && calm > 4'h8 |-> ulpi_data_out[3:2] == code; endproperty
   a_supply: assert property (p_supply) else $error("supply code wrong");
   property p_upper;
      ulpi_data_oe && calm > 4'h8 |-> ulpi_data_out[7:4] == upper_status;
   endproperty
   a_upper: assert property (p_upper) else $error("upper bits wrong");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rvalid); endproperty
   a_rhold: assert property (p_rhold) else $error("rvalid dropped");
endmodule : urs_status_sender_asserts
bind urs_status_sender urs_status_sender_asserts i_urs_status_sender_asserts (.clk_sys, .rst_n,
   .line_dp, .line_dm, .sess_end, .sess_vld, .a_device_supply_valid_flag, .upper_status,
   .ulpi_dir, .ulpi_nxt, .ulpi_data_out, .ulpi_data_oe, .s_axi_bvalid, .s_axi_bready,
   .s_axi_rvalid, .s_axi_rready);

// *** tb/urs_status_sender_tb.sv ***
// Self-checking bench for the status byte sender
`timescale 1ns/1ps
module urs_status_sender_tb;
   import urs_pkg::*;
   logic clk_sys = 0, rst_n = 0, line_dp = 0, line_dm = 0, sess_end = 1, sess_vld = 0;
   logic a_device_supply_valid_flag = 0, link_busy = 0, got, armed = 0;
   logic [3:0] upper_status = 0, s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic ulpi_dir, ulpi_nxt, ulpi_data_oe, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] ulpi_data_out, got_byte, last = 8'h00;
   logic [7:0] exp_q[$];
   int failures = 0, comparisons = 0, seed = 89, n, k;
   urs_status_sender i_urs_status_sender (.clk_sys, .rst_n, .line_dp, .line_dm, .sess_end,
      .sess_vld, .a_device_supply_valid_flag, .upper_status, .link_busy, .ulpi_dir, .ulpi_nxt,
      .ulpi_data_out, .ulpi_data_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
   urs_link_model i_urs_link_model (.clk_sys, .rst_n, .ulpi_dir, .ulpi_nxt, .ulpi_data_out,
      .ulpi_data_oe, .got, .got_byte);
   // Clock and random link pressure
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) link_busy <= ($random(seed) & 3) == 0;
   // Compare each received byte with the oldest note, once settled
   always @(negedge clk_sys) begin
      if (armed && got === 1'b1) begin
         if (exp_q.size() == 0) check("byte", 32'h0, 32'h100);
         else check("byte", {24'h0, exp_q.pop_front()}, {24'h0, got_byte});
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, seen);
         failures++;
      end
   endtask : check
   task automatic conclude;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task automatic give_up;
      check("wait", 32'h0, 32'h1);
      conclude();
   endtask : give_up
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50 && s_axi_bvalid !== 1'b1; k++) begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      check("bresp", {30'h0, URS_RESP_OKAY}, {30'h0, s_axi_bresp});
      if (k == 50) give_up();
   endtask : axi_write
   task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50 && s_axi_rvalid !== 1'b1; k++) begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      check("rresp", {30'h0, URS_RESP_OKAY}, {30'h0, s_axi_rresp});
      if (k == 50) give_up();
   endtask : axi_read
   // Change pins or upper bits and note the byte that must follow
   task automatic set_pins(input logic [1:0] c, input logic up);
      logic [7:0] r;
      @(posedge clk_sys);
      r = 8'($random(seed));
      if (up) begin
         upper_status <= last[7:4] ^ {r[7:5], 1'b1};
         last = {last[7:4] ^ {r[7:5], 1'b1}, last[3:0]};
      end else begin
         line_dp <= ~last[0];
         line_dm <= r[0];
         sess_end <= (c == 2'h0) | (c[1] & r[1]);
         sess_vld <= (c == 2'h2) | ((c == 2'h3) & r[2]);
         a_device_supply_valid_flag <= c == 2'h3;
         last = {last[7:4], c, r[0], ~last[0]};
      end
      exp_q.push_back(last);
   endtask : set_pins
   task automatic wait_send;
      for (k = 0; k < 40 && ulpi_dir !== 1'b1; k++) @(negedge clk_sys);
      if (k == 40) give_up();
      for (k = 0; k < 40 && ulpi_dir !== 1'b0; k++) @(negedge clk_sys);
      if (k == 40) give_up();
      repeat (3) @(posedge clk_sys);
   endtask : wait_send
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (30) @(posedge clk_sys);
      armed = 1'b1;
      axi_read(URS_OFS_CTRL, rd);
      check("ctrl", 32'h1, rd & 32'h3);
      axi_read(URS_OFS_MASK, rd);
      check("mask", 32'h0, rd & 32'h7);
      for (n = 0; n < 12; n++) begin
         set_pins(n[2:1], n[0]);
         wait_send();
      end
      @(negedge clk_sys);
      check("irq masked", 32'h0, {31'h0, irq});
      axi_write(URS_OFS_MASK, 32'h4);
      @(negedge clk_sys);
      check("irq raised", 32'h1, {31'h0, irq});
      axi_write(URS_OFS_EVENT, 32'h7);
      @(negedge clk_sys);
      check("irq cleared", 32'h0, {31'h0, irq});
      set_pins(2'h1, 1'b0);
      wait_send();
      check("irq pair", 32'h1, {31'h0, irq});
      axi_read(URS_OFS_BYTE, rd);
      check("sent byte", {24'h0, last}, rd & 32'hff);
      axi_write(URS_OFS_CTRL, 32'h0);
      set_pins(2'h2, 1'b0);
      n = 0;
      repeat (20) begin
         @(negedge clk_sys);
         n = n + (ulpi_dir === 1'b1);
      end
      check("dir held", 32'h0, n);
      @(posedge clk_sys);
      axi_write(URS_OFS_CTRL, 32'h1);
      wait_send();
      // Forced send repeats the unchanged byte once, then self clears
      axi_write(URS_OFS_CTRL, 32'h3);
      exp_q.push_back(last);
      wait_send();
      axi_read(URS_OFS_CTRL, rd);
      check("force cleared", 32'h1, rd & 32'h3);
      repeat (4) @(posedge clk_sys);
      check("pending bytes", 32'h0, exp_q.size());
      conclude();
   end
endmodule : urs_status_sender_tb
